/* File: inc/e3_alarm_pkg.sv */
// constants and register map of the receive alarm detector
// Operation
// - signal loss is declared after 32 consecutive zero line bits or while the external loss input is high.
// - on declaring signal loss the loss pin goes high and bit 4 of status register two is set.
// - declaring signal loss sets the loss interrupt status bit, bit 1 of interrupt status one.
// - signal loss clears after a 32-bit span without any run of 4 consecutive zeros.
// - clearing signal loss raises the loss interrupt again and drops bit 4 and the loss pin.
// - all-ones alarm is declared when two consecutive frames each hold seven or fewer zeros.
// - declaring the all-ones alarm sets bit 0 of interrupt status one.
// - declaring the all-ones alarm raises its pin and sets bit 3 of status register two.
// - the all-ones alarm clears when two consecutive frames each hold eight or more zeros.
// - clearing the all-ones alarm raises its interrupt and drops its status bit and pin.
// - remote failure is declared after a selectable run of frames whose maintenance byte bit 7 is one.
// - bit 4 of config register one selects the run length, zero for 3 frames and one for 5.
// - declaring remote failure sets bit 3 of interrupt status two and bit 0 of status register two.
// - remote failure clears after the selected run of frames without the flag, with an interrupt and bit 0 cleared.
// - interrupt enable register two at 0x13 holds writable enables, remote failure at bit 3.
package e3_alarm_pkg;
  // register indices; each register is one aligned word, so the bus address is four times the index
  localparam logic [7:0] CFG_ONE_IDX = 8'h10;
  localparam logic [7:0] STAT_TWO_IDX = 8'h11;
  localparam logic [7:0] IEN_TWO_IDX = 8'h13;
  localparam logic [7:0] IST_ONE_IDX = 8'h14;
  localparam logic [7:0] IST_TWO_IDX = 8'h15;
  localparam logic [7:0] IEN_ONE_IDX = 8'h12;
  localparam int LOS_ZERO_RUN = 32;
  localparam int LOS_CLEAR_SPAN = 32;
  localparam int LOS_CLEAR_ZEROS = 4;
  localparam int AIS_MAX_ZEROS = 7;
  localparam int AIS_FRAMES = 2;
  localparam int RRF_SHORT = 3;
  localparam int RRF_LONG = 5;
  localparam int CFG_RRF_SEL_BIT = 4;
  localparam int ST_LOS_BIT = 4;
  localparam int ST_AIS_BIT = 3;
  localparam int ST_RRF_BIT = 0;
  localparam int IS1_LOS_BIT = 1;
  localparam int IS1_AIS_BIT = 0;
  localparam int IS2_RRF_BIT = 3;
  localparam int MA_RRF_BIT = 7;
  localparam logic [7:0] CFG_ONE_RESET = 8'h00;
  localparam logic [7:0] IEN_TWO_RESET = 8'h08;
  localparam logic [7:0] IEN_ONE_RESET = 8'h00;
  localparam logic [7:0] IEN_TWO_MASK = 8'h5f;
  localparam logic [7:0] IEN_ONE_MASK = 8'h03;
endpackage

/* File: rtl/e3_frame_counter.sv */
`timescale 1ns/1ps
// consecutive-frame run counter for the remote failure flag
module e3_frame_counter #(
  parameter int WIDTH = 3
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic frame_i,
  input wire logic flag_i,
  input wire logic state_i,
  input wire logic [WIDTH-1:0] need_i,
  output logic change_o
);
  logic [WIDTH-1:0] run_q;
  logic [WIDTH-1:0] run_d;
  wire logic differs = flag_i != state_i;
  wire logic [WIDTH-1:0] run_inc = run_q + 1'b1;
  // a frame agreeing with the current state restarts the run
  assign run_d = !frame_i ? run_q : (differs ? run_inc : '0);
  assign change_o = frame_i && differs && (run_inc >= need_i);
  always_ff @(posedge clk_i)
  begin
    if (srst_i || change_o)
      run_q <= '0;
    else
      run_q <= run_d;
  end
endmodule

/* File: rtl/e3_rx_alarm_detector.sv */
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// receive alarm detector: signal loss, all-ones alarm, remote failure, apb registers
module e3_rx_alarm_detector (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic LINE_DATA_I,
  input wire logic LINE_VALID_I,
  input wire logic FRAME_END_I,
  input wire logic [7:0] MAINT_BYTE_I,
  input wire logic MAINT_VALID_I,
  input wire logic EXT_LOSS_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic SIGNAL_LOSS_O,
  output logic ALL_ONES_ALARM_O,
  output logic REMOTE_FAILURE_O,
  output logic IRQ_O
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] ext_sync_q;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
      ext_sync_q <= 2'h0;
    else
      ext_sync_q <= {ext_sync_q[0], EXT_LOSS_I};
  end
  wire logic ext_loss = ext_sync_q[1];

  // ----------------------------------------
  // signal loss
  // ----------------------------------------
  logic [5:0] zero_run_q;
  logic [5:0] span_q;
  logic [2:0] short_run_q;
  logic los_q;
  wire logic bit_zero = LINE_VALID_I && !LINE_DATA_I;
  wire logic bit_one = LINE_VALID_I && LINE_DATA_I;
  wire logic los_declare = !los_q && (ext_loss ||
    (bit_zero && zero_run_q == 6'(e3_alarm_pkg::LOS_ZERO_RUN - 1)));
  wire logic short_hit = bit_zero && short_run_q == 3'(e3_alarm_pkg::LOS_CLEAR_ZEROS - 1);
  // span restarts whenever four zeros in a row are seen
  wire logic los_clear = los_q && !ext_loss && LINE_VALID_I && !short_hit &&
    span_q == 6'(e3_alarm_pkg::LOS_CLEAR_SPAN - 1);
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I || bit_one)
      zero_run_q <= 6'h00;
    else if (bit_zero && zero_run_q != 6'(e3_alarm_pkg::LOS_ZERO_RUN - 1))
      zero_run_q <= zero_run_q + 6'h01;
  end

  // short run holds at its limit: a fifth zero is a new four-zero run too
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I || bit_one)
      short_run_q <= 3'h0;
    else if (bit_zero && !short_hit)
      short_run_q <= short_run_q + 3'h1;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I || !los_q || short_hit || los_clear)
      span_q <= 6'h00;
    else if (LINE_VALID_I)
      span_q <= span_q + 6'h01;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
      los_q <= 1'b0;
    else if (los_declare)
      los_q <= 1'b1;
    else if (los_clear)
      los_q <= 1'b0;
  end

  // ----------------------------------------
  // all-ones alarm
  // ----------------------------------------
  logic [3:0] frame_zeros_q;
  logic ais_run_q;
  logic ais_q;
  // count saturates at eight: only "eight or more" matters
  wire logic frame_heavy = frame_zeros_q > 4'(e3_alarm_pkg::AIS_MAX_ZEROS);
  wire logic frame_sparse = !frame_heavy;
  wire logic frame_differs = ais_q ? frame_heavy : frame_sparse;
  wire logic ais_change = FRAME_END_I && frame_differs && ais_run_q;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      frame_zeros_q <= 4'h0;
      ais_run_q <= 1'b0;
      ais_q <= 1'b0;
    end
    else
    begin
      if (FRAME_END_I)
        frame_zeros_q <= 4'h0;
      else if (bit_zero && !frame_zeros_q[3])
        frame_zeros_q <= frame_zeros_q + 4'h1;
      if (FRAME_END_I)
        ais_run_q <= frame_differs && !ais_run_q;
      if (ais_change)
        ais_q <= !ais_q;
    end
  end

  // ----------------------------------------
  // remote receive failure
  // ----------------------------------------
  logic [7:0] cfg_one_q;
  logic rrf_q;
  logic rrf_change;
  wire logic [2:0] rrf_need = cfg_one_q[e3_alarm_pkg::CFG_RRF_SEL_BIT] ?
    3'(e3_alarm_pkg::RRF_LONG) : 3'(e3_alarm_pkg::RRF_SHORT);
  e3_frame_counter #(
    .WIDTH(3)
  ) u_rrf_count (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .frame_i(MAINT_VALID_I),
    .flag_i(MAINT_BYTE_I[e3_alarm_pkg::MA_RRF_BIT]),
    .state_i(rrf_q),
    .need_i(rrf_need),
    .change_o(rrf_change)
  );
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
      rrf_q <= 1'b0;
    else if (rrf_change)
      rrf_q <= !rrf_q;
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic [7:0] ien_one_q;
  logic [7:0] ien_two_q;
  logic [7:0] ist_one_q;
  logic [7:0] ist_two_q;
  logic [31:0] rdata_q;
  logic ready_q;

  // registers sit on aligned words: bus address is four times the index
  function automatic logic [7:0] word_addr(input logic [7:0] idx);
    return {idx[5:0], 2'h0};
  endfunction

  wire logic access = PSEL_I && PENABLE_I;
  // one wait state: read data is latched in the first access cycle so it
  // stands at the completing edge; costs one cycle per transfer
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
      ready_q <= 1'b0;
    else
      ready_q <= access && !ready_q;
  end

  wire logic done = access && ready_q;
  wire logic wr = done && PWRITE_I;
  // read side effects happen once, in the first access cycle
  wire logic rd = access && !ready_q && !PWRITE_I;
  wire logic sel_cfg = PADDR_I == word_addr(e3_alarm_pkg::CFG_ONE_IDX);
  wire logic sel_st = PADDR_I == word_addr(e3_alarm_pkg::STAT_TWO_IDX);
  wire logic sel_ie1 = PADDR_I == word_addr(e3_alarm_pkg::IEN_ONE_IDX);
  wire logic sel_ie2 = PADDR_I == word_addr(e3_alarm_pkg::IEN_TWO_IDX);
  wire logic sel_is1 = PADDR_I == word_addr(e3_alarm_pkg::IST_ONE_IDX);
  wire logic sel_is2 = PADDR_I == word_addr(e3_alarm_pkg::IST_TWO_IDX);
  wire logic mapped = sel_cfg || sel_st || sel_ie1 || sel_ie2 || sel_is1 || sel_is2;
  wire logic [7:0] stat_two = {3'h0, los_q, ais_q, 2'h0, rrf_q};
  wire logic [7:0] ev_one = {6'h00, los_declare || los_clear, ais_change};
  wire logic [7:0] ev_two = {4'h0, rrf_change, 3'h0};
  wire logic [7:0] rd_byte = sel_cfg ? cfg_one_q :
                             sel_st ? stat_two :
                             sel_ie1 ? ien_one_q :
                             sel_ie2 ? ien_two_q :
                             sel_is1 ? ist_one_q :
                             sel_is2 ? ist_two_q : 8'h00;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      cfg_one_q <= e3_alarm_pkg::CFG_ONE_RESET;
      ien_one_q <= e3_alarm_pkg::IEN_ONE_RESET;
      ien_two_q <= e3_alarm_pkg::IEN_TWO_RESET;
    end
    else
    begin
      if (wr && sel_cfg)
        cfg_one_q <= PWDATA_I[7:0];
      if (wr && sel_ie1)
        ien_one_q <= PWDATA_I[7:0] & e3_alarm_pkg::IEN_ONE_MASK;
      if (wr && sel_ie2)
        ien_two_q <= PWDATA_I[7:0] & e3_alarm_pkg::IEN_TWO_MASK;
    end
  end

  // clear on read in the same cycle the data is latched; a coincident
  // event survives, a later one waits for the next read
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      ist_one_q <= 8'h00;
      ist_two_q <= 8'h00;
    end
    else
    begin
      ist_one_q <= ((rd && sel_is1) ? 8'h00 : ist_one_q) | ev_one;
      ist_two_q <= ((rd && sel_is2) ? 8'h00 : ist_two_q) | ev_two;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
      rdata_q <= 32'h0000_0000;
    else if (rd)
      rdata_q <= {24'h00_0000, rd_byte};
  end

  assign PREADY_O = ready_q;
  assign PSLVERR_O = access && !mapped;
  assign PRDATA_O = rdata_q;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic irq_q;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
      irq_q <= 1'b0;
    else
      irq_q <= |(ist_one_q & ien_one_q) || |(ist_two_q & ien_two_q);
  end
  assign IRQ_O = irq_q;
  assign SIGNAL_LOSS_O = los_q;
  assign ALL_ONES_ALARM_O = ais_q;
  assign REMOTE_FAILURE_O = rrf_q;
endmodule

/* File: dv/e3_rx_alarm_detector_sva.sv */
// port checker for the receive alarm detector
`timescale 1ns/1ps
module e3_rx_alarm_detector_sva (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic LINE_DATA_I,
  input wire logic LINE_VALID_I,
  input wire logic FRAME_END_I,
  input wire logic [7:0] MAINT_BYTE_I,
  input wire logic MAINT_VALID_I,
  input wire logic EXT_LOSS_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic PSLVERR_O,
  input wire logic SIGNAL_LOSS_O,
  input wire logic ALL_ONES_ALARM_O,
  input wire logic REMOTE_FAILURE_O,
  input wire logic IRQ_O
);
  // ------------------------------
  // run counters, saturating
  // ------------------------------
  logic [5:0] zrun_q;
  logic [2:0] frun_q;
  logic [2:0] nrun_q;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I || (LINE_VALID_I && LINE_DATA_I)) zrun_q <= 6'h00;
    else if (LINE_VALID_I && zrun_q != 6'h3f) zrun_q <= zrun_q + 6'h01;
  end
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I || (MAINT_VALID_I && !MAINT_BYTE_I[7])) frun_q <= 3'h0;
    else if (MAINT_VALID_I && frun_q != 3'h7) frun_q <= frun_q + 3'h1;
    if (SRST_I || (MAINT_VALID_I && MAINT_BYTE_I[7])) nrun_q <= 3'h0;
    else if (MAINT_VALID_I && nrun_q != 3'h7) nrun_q <= nrun_q + 3'h1;
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  loss_set_a: assert property (zrun_q == 6'h20 |-> ##[0:3] SIGNAL_LOSS_O)
    else $error("loss pin not raised");
  ext_loss_a: assert property (EXT_LOSS_I [*4] |-> ##[0:2] SIGNAL_LOSS_O)
    else $error("external loss ignored");
  loss_clear_a: assert property ($fell(SIGNAL_LOSS_O) |-> zrun_q < 6'h04)
    else $error("loss cleared too early");
  alarm_frame_a: assert property ($changed(ALL_ONES_ALARM_O) |-> $past(FRAME_END_I) || $past(FRAME_END_I, 2))
    else $error("alarm moved off frame end");
  remote_set_a: assert property ($rose(REMOTE_FAILURE_O) |-> frun_q >= 3'h3)
    else $error("remote failure set early");
  remote_clear_a: assert property ($fell(REMOTE_FAILURE_O) |-> nrun_q >= 3'h3)
    else $error("remote failure cleared early");
  unmapped_a: assert property (PSEL_I && PENABLE_I && (PADDR_I[1:0] != 2'h0 || PADDR_I[7:2] < 6'h10 || PADDR_I[7:2] > 6'h15) |-> PSLVERR_O)
    else $error("unmapped access not refused");
  reset_quiet_a: assert property (disable iff (1'b0) SRST_I |=> !SIGNAL_LOSS_O && !ALL_ONES_ALARM_O && !IRQ_O)
    else $error("outputs active after reset");
endmodule

/* File: dv/e3_line_source.sv */
// remote terminal model: line bits, frame ends, maintenance bytes
`timescale 1ns/1ps
module e3_line_source #(
  parameter int FRAME_BITS = 48
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] mode_i,
  input wire logic flag_i,
  output logic line_data_o,
  output logic line_valid_o,
  output logic frame_end_o,
  output logic [7:0] maint_byte_o,
  output logic maint_valid_o
);
  // mode 0 all zeros, 1 all ones, 2 alternating
  logic [7:0] pos_q;
  always_ff @(posedge clk_i)
  begin
    pos_q <= (srst_i || frame_end_o) ? 8'h00 : pos_q + 8'h01;
  end
  assign frame_end_o = !srst_i && pos_q == 8'(FRAME_BITS - 1);
  assign maint_valid_o = frame_end_o;
  assign line_valid_o = !srst_i && !frame_end_o;
  // idle cycles carry the low position bit, one at every frame end, so no stale level is mistaken for data
  assign line_data_o = line_valid_o ? (mode_i == 2'h1 || (mode_i == 2'h2 && pos_q[0])) : pos_q[0];
  assign maint_byte_o = frame_end_o ? {flag_i, pos_q[6:0]} : {~flag_i, ~pos_q[6:0]};
endmodule

/* File: dv/e3_rx_alarm_detector_tb.sv */
// self-checking bench for the receive alarm detector
`timescale 1ns/1ps
module e3_rx_alarm_detector_tb;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_loss = 1'b0, flag = 1'b0, ld, lv, fe, mv, pready, pslverr, irq, err;
  logic [1:0] mode = 2'h2;
  logic [2:0] pins;
  logic [7:0] paddr = 8'h00, mb, v;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int num_errors = 0, n_compared = 0, cyc = 0, seed = 37690;
  e3_line_source u_src (.clk_i(clk), .srst_i(srst), .mode_i(mode), .flag_i(flag), .line_data_o(ld),
    .line_valid_o(lv), .frame_end_o(fe), .maint_byte_o(mb), .maint_valid_o(mv));
  e3_rx_alarm_detector u_dut (.CORE_CLK_I(clk), .SRST_I(srst), .LINE_DATA_I(ld), .LINE_VALID_I(lv),
    .FRAME_END_I(fe), .MAINT_BYTE_I(mb), .MAINT_VALID_I(mv), .EXT_LOSS_I(ext_loss), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SIGNAL_LOSS_O(pins[0]), .ALL_ONES_ALARM_O(pins[1]),
    .REMOTE_FAILURE_O(pins[2]), .IRQ_O(irq));
  function int run_len(input logic sel);
    return sel ? e3_alarm_pkg::RRF_LONG : e3_alarm_pkg::RRF_SHORT;
  endfunction
  task close_out();
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // a is a register index; the bus sees four times it
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {a[5:0], 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    err = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task frames(input int n);
    repeat (n) @(posedge clk iff fe);
    repeat (3) @(posedge clk);
  endtask
  task wait_pin(input int k, input logic lvl);
    for (int i = 0; i < 2000 && pins[k] !== lvl; i++) @(posedge clk);
    chk(pins[k], lvl);
  endtask
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(e3_alarm_pkg::CFG_ONE_IDX, 32'h0);
    rd(e3_alarm_pkg::IEN_TWO_IDX, 32'h8);
    rd(8'h20, 32'h0);
    chk(err, 1'b1);
    ext_loss <= 1'b1;
    wait_pin(0, 1'b1);
    ext_loss <= 1'b0;
    wait_pin(0, 1'b0);
    rd(e3_alarm_pkg::IST_ONE_IDX, 32'h2);
    rd(e3_alarm_pkg::IST_ONE_IDX, 32'h0);
    mode <= 2'h0;
    wait_pin(0, 1'b1);
    rd(e3_alarm_pkg::STAT_TWO_IDX, 32'h10);
    rd(e3_alarm_pkg::IST_ONE_IDX, 32'h2);
    mode <= 2'h2;
    wait_pin(0, 1'b0);
    rd(e3_alarm_pkg::STAT_TWO_IDX, 32'h0);
    rd(e3_alarm_pkg::IST_ONE_IDX, 32'h2);
    mode <= 2'h1;
    wait_pin(1, 1'b1);
    rd(e3_alarm_pkg::STAT_TWO_IDX, 32'h8);
    rd(e3_alarm_pkg::IST_ONE_IDX, 32'h1);
    mode <= 2'h2;
    wait_pin(1, 1'b0);
    rd(e3_alarm_pkg::STAT_TWO_IDX, 32'h0);
    rd(e3_alarm_pkg::IST_ONE_IDX, 32'h1);
    for (int s = 0; s < 2; s++)
    begin
      v = 8'($random(seed));
      v[4] = s[0];
      apb(1'b1, e3_alarm_pkg::CFG_ONE_IDX, {24'h0, v});
      rd(e3_alarm_pkg::CFG_ONE_IDX, {24'h0, v});
      if (s == 1)
      begin
        apb(1'b1, e3_alarm_pkg::IEN_TWO_IDX, {24'h0, v & 8'h57});
        rd(e3_alarm_pkg::IEN_TWO_IDX, {24'h0, v & 8'h57});
      end
      flag <= 1'b1;
      frames(run_len(v[4]) - 1);
      chk(pins[2], 1'b0);
      frames(1);
      chk(pins[2], 1'b1);
      chk(irq, 1'(s == 0));
      rd(e3_alarm_pkg::IST_TWO_IDX, 32'h8);
      rd(e3_alarm_pkg::STAT_TWO_IDX, 32'h1);
      chk(irq, 1'b0);
      flag <= 1'b0;
      frames(run_len(v[4]) - 1);
      chk(pins[2], 1'b1);
      frames(1);
      chk(pins[2], 1'b0);
      rd(e3_alarm_pkg::IST_TWO_IDX, 32'h8);
    end
    close_out();
  end
endmodule
bind e3_rx_alarm_detector e3_rx_alarm_detector_sva u_sva (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I),
  .LINE_DATA_I(LINE_DATA_I), .LINE_VALID_I(LINE_VALID_I), .FRAME_END_I(FRAME_END_I),
  .MAINT_BYTE_I(MAINT_BYTE_I), .MAINT_VALID_I(MAINT_VALID_I), .EXT_LOSS_I(EXT_LOSS_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PSLVERR_O(PSLVERR_O), .SIGNAL_LOSS_O(SIGNAL_LOSS_O),
  .ALL_ONES_ALARM_O(ALL_ONES_ALARM_O), .REMOTE_FAILURE_O(REMOTE_FAILURE_O), .IRQ_O(IRQ_O));
